// ### logic/dla_consts.svh
`ifndef DLA_CONSTS_SVH
`define DLA_CONSTS_SVH

// ==========================================================
// Serial clock derivation
`define DLA_DIV_W             3
`define DLA_VCO_DIV_LAST      3'h7

// ==========================================================
// Acknowledge timing, in serial clock ticks or clk_i cycles
`define DLA_GAP_W             6
`define DLA_MIN_GAP_TICKS     6'h20
`define DLA_LOW_W             4
`define DLA_ACK_LOW_LAST      4'hF
`define DLA_SPD_W             2
`define DLA_SPEEDUP_LAST      2'h1

// ==========================================================
// Check helpers: 16 ticks of 8 cycles, 32 ticks of 8 cycles
`define DLA_LOW_CLK_W         7
`define DLA_ACK_LOW_CLK_LAST  7'h7F
`define DLA_SINCE_W           9
`define DLA_MIN_GAP_CLKS      9'h100
`define DLA_SINCE_MAX         9'h1FF

`endif

// ### logic/dla_pkg.sv
package dla_pkg;

  typedef enum logic [1:0] {
    ACK_IDLE,
    ACK_WAIT,
    ACK_LOW,
    ACK_SPEEDUP
  } ack_state_e;

endpackage

// ### logic/serial_tick_gen.sv
`timescale 1ns/10ps
`default_nettype none
`include "dla_consts.svh"

module serial_tick_gen (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // Control
  input  wire logic restart_i,
  // Serial clock tick
  output logic      tick_o
);

  logic [`DLA_DIV_W-1:0] div_reg;
  logic [`DLA_DIV_W-1:0] div_next;
  wire                   div_last;

  // ==========================================================
  // Divide-by-eight counter

  // The serial rate is always the VCO rate over eight; restart aligns the
  // tick train to the end of a command so the minimum gap is exact.
  assign div_last = (div_reg == `DLA_VCO_DIV_LAST);
  assign div_next = (restart_i || div_last) ? '0 : div_reg + 1'b1;
  assign tick_o   = div_last && !restart_i;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_next;
    end
  end

  // ==========================================================
  // Checks

  property p_tick_period;
    @(posedge clk_i) disable iff (reset_i)
    restart_i |=> (!tick_o)[*7] ##1 tick_o;
  endproperty
  a_tick_period: assert property (p_tick_period)
    else $error("Serial tick not eight cycles after restart.");

endmodule
`default_nettype wire

// ### logic/debug_link_ack_handshake.sv
// Summary of operation
// - Serial clock is the VCO clock divided by eight, always.
// - Acknowledge is 16 serial ticks low, then a brief driven-high speedup.
// - Acknowledge only after the command has been executed successfully.
// - Acknowledge starts no sooner than 32 ticks after the command ends.
// - Wait or stop before execution drops the pending command, no acknowledge.
// - Wait or stop during command reception discards that command unacknowledged.
// - Byte read: opcode and address, decode, bus cycle, read, then acknowledge.
// - The device starts the acknowledge with a falling edge on the pin.
// - Except speedup pulses, highs come from the pull-up, never driven.
// - Device lets the host abort a pending command and its acknowledge.
// - Command execution runs at bus rate, independent of the serial clock.
`timescale 1ns/10ps
`default_nettype none
`include "dla_consts.svh"

module debug_link_ack_handshake (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // Command receiver side
  input  wire logic cmd_receiving_i,
  input  wire logic cmd_end_i,
  input  wire logic abort_i,
  input  wire logic ack_enable_i,
  input  wire logic ack_disable_i,
  output logic      cmd_drop_o,
  // CPU bus access side
  output logic      exec_req_o,
  input  wire logic exec_done_i,
  input  wire logic cpu_lowpower_i,
  // Status
  output logic      pending_o,
  output logic      ack_busy_o,
  output logic      ack_en_o,
  // Single-wire debug pin, open drain with speedup
  input  wire logic single_wire_debug_pin_i,
  output logic      single_wire_debug_pin_o,
  output logic      single_wire_debug_pin_oe_o,
  output logic      pin_level_o
);

  dla_pkg::ack_state_e state_reg;
  dla_pkg::ack_state_e state_next;
  logic                      tick, done_reg, discard_reg, ack_en_reg, drop_reg;
  logic                      pin_oe_reg, pin_out_reg, pin_meta_reg, pin_sync_reg;
  logic [`DLA_GAP_W-1:0]     gap_reg, gap_next;
  logic [`DLA_LOW_W-1:0]     low_reg, low_next;
  logic [`DLA_SPD_W-1:0]     spd_reg, spd_next;
  logic [`DLA_LOW_CLK_W-1:0] low_clk_reg;
  logic [`DLA_SINCE_W-1:0]   since_reg;
  wire in_idle, in_wait, in_low, in_spd, cmd_bad, cmd_accept, gap_met, lost_exec;
  wire ack_start, ack_skip, low_end, spd_end, next_drive, next_high;

  // ==========================================================
  // Serial clock
  serial_tick_gen u_tick (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .restart_i (cmd_accept),
    .tick_o    (tick)
  );

  // ==========================================================
  // Decode
  assign in_idle    = (state_reg == dla_pkg::ACK_IDLE);
  assign in_wait    = (state_reg == dla_pkg::ACK_WAIT);
  assign in_low     = (state_reg == dla_pkg::ACK_LOW);
  assign in_spd     = (state_reg == dla_pkg::ACK_SPEEDUP);
  assign cmd_bad    = discard_reg || cpu_lowpower_i;
  assign cmd_accept = cmd_end_i && in_idle && !cmd_bad;
  assign gap_met    = (gap_reg == `DLA_MIN_GAP_TICKS);
  assign lost_exec  = in_wait && !done_reg && cpu_lowpower_i;
  // Start on a tick so the low phase is whole serial periods long.
  assign ack_start  = in_wait && done_reg && ack_en_reg && gap_met && tick;
  assign ack_skip   = in_wait && done_reg && !ack_en_reg;
  assign low_end    = in_low && tick && (low_reg == `DLA_ACK_LOW_LAST);
  assign spd_end    = in_spd && (spd_reg == `DLA_SPEEDUP_LAST);
  assign next_drive = (state_next == dla_pkg::ACK_LOW) || (state_next == dla_pkg::ACK_SPEEDUP);
  assign next_high  = (state_next == dla_pkg::ACK_SPEEDUP);
  // Phase counters clear whenever their state is left, so an abort leaves no stale count.
  assign gap_next   = !in_wait ? '0 : ((tick && !gap_met) ? gap_reg + 1'b1 : gap_reg);
  assign low_next   = !in_low ? '0 : (tick ? low_reg + 1'b1 : low_reg);
  assign spd_next   = !in_spd ? '0 : spd_reg + 1'b1;

  // Execution is requested on the bus clock; only the handshake uses ticks.
  assign exec_req_o = in_wait && !done_reg;
  assign pending_o  = in_wait;
  assign ack_busy_o = in_low || in_spd;
  assign ack_en_o   = ack_en_reg;
  assign cmd_drop_o = drop_reg;
  assign pin_level_o                = pin_sync_reg;
  assign single_wire_debug_pin_o    = pin_out_reg;
  assign single_wire_debug_pin_oe_o = pin_oe_reg;

  always_comb begin
    state_next = state_reg;
    if (abort_i) begin
      state_next = dla_pkg::ACK_IDLE;
    end else begin
      case (state_reg)
        dla_pkg::ACK_IDLE: begin
          if (cmd_accept) begin
            state_next = dla_pkg::ACK_WAIT;
          end
        end
        dla_pkg::ACK_WAIT: begin
          if (lost_exec || ack_skip) begin
            state_next = dla_pkg::ACK_IDLE;
          end else if (ack_start) begin
            state_next = dla_pkg::ACK_LOW;
          end
        end
        dla_pkg::ACK_LOW: begin
          if (low_end) begin
            state_next = dla_pkg::ACK_SPEEDUP;
          end
        end
        dla_pkg::ACK_SPEEDUP: begin
          if (spd_end) begin
            state_next = dla_pkg::ACK_IDLE;
          end
        end
        default: begin
          state_next = dla_pkg::ACK_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= dla_pkg::ACK_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Completion is kept only while the command stays pending, so a completion
  // that meets an abort cannot leak into a command accepted right after it.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      done_reg <= 1'b0;
    end else if (state_next != dla_pkg::ACK_WAIT) begin
      done_reg <= 1'b0;
    end else if (in_wait && exec_done_i) begin
      done_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      gap_reg <= '0;
      low_reg <= '0;
      spd_reg <= '0;
    end else begin
      gap_reg <= gap_next;
      low_reg <= low_next;
      spd_reg <= spd_next;
    end
  end

  // A reception corrupted by wait or stop is remembered until its end or an abort. The end
  // closes its own discard, so the following command is not dropped as well.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      discard_reg <= 1'b0;
    end else if (cmd_end_i || abort_i) begin
      discard_reg <= 1'b0;
    end else if (cmd_receiving_i && cpu_lowpower_i) begin
      discard_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_en_reg <= 1'b0;
      drop_reg   <= 1'b0;
    end else begin
      ack_en_reg <= ack_enable_i ? 1'b1 : (ack_disable_i ? 1'b0 : ack_en_reg);
      drop_reg   <= cmd_end_i && cmd_bad;
    end
  end

  // ==========================================================
  // Pin drive and sampling
  // High is driven only in the speedup phase; otherwise the pull-up lifts it.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_oe_reg   <= 1'b0;
      pin_out_reg  <= 1'b0;
      pin_meta_reg <= 1'b1;
      pin_sync_reg <= 1'b1;
    end else begin
      pin_oe_reg   <= next_drive;
      pin_out_reg  <= next_high;
      pin_meta_reg <= single_wire_debug_pin_i;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ==========================================================
  // Checks
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      low_clk_reg <= '0;
      since_reg   <= '0;
    end else begin
      low_clk_reg <= in_low ? low_clk_reg + 1'b1 : '0;
      if (cmd_accept) begin
        since_reg <= '0;
      end else if (since_reg != `DLA_SINCE_MAX) begin
        since_reg <= since_reg + 1'b1;
      end
    end
  end

  property p_low_len;
    @(posedge clk_i) disable iff (reset_i)
    (in_low && state_next == dla_pkg::ACK_SPEEDUP) |-> (low_clk_reg == `DLA_ACK_LOW_CLK_LAST);
  endproperty
  a_low_len: assert property (p_low_len)
    else $error("Acknowledge low phase is not sixteen serial ticks.");
  property p_falling_start;
    @(posedge clk_i) disable iff (reset_i)
    (in_wait && state_next == dla_pkg::ACK_LOW) |=>
      single_wire_debug_pin_oe_o && !single_wire_debug_pin_o;
  endproperty
  a_falling_start: assert property (p_falling_start)
    else $error("Acknowledge did not begin by driving the pin low.");
  property p_high_only_speedup;
    @(posedge clk_i) disable iff (reset_i)
    (single_wire_debug_pin_oe_o && single_wire_debug_pin_o) |-> in_spd;
  endproperty
  a_high_only_speedup: assert property (p_high_only_speedup)
    else $error("Pin driven high outside a speedup pulse.");
  property p_min_gap;
    @(posedge clk_i) disable iff (reset_i)
    $rose(in_low) |-> (since_reg > `DLA_MIN_GAP_CLKS);
  endproperty
  a_min_gap: assert property (p_min_gap)
    else $error("Acknowledge started before thirty-two serial ticks.");
  property p_after_exec;
    @(posedge clk_i) disable iff (reset_i)
    (in_wait && state_next == dla_pkg::ACK_LOW) |-> done_reg && ack_en_reg;
  endproperty
  a_after_exec: assert property (p_after_exec)
    else $error("Acknowledge started without executed command.");
  property p_lost_on_lowpower;
    @(posedge clk_i) disable iff (reset_i)
    (in_wait && !done_reg && cpu_lowpower_i) |=> in_idle && !single_wire_debug_pin_oe_o;
  endproperty
  a_lost_on_lowpower: assert property (p_lost_on_lowpower)
    else $error("Pending command kept after wait or stop.");
  property p_discard_rx;
    @(posedge clk_i) disable iff (reset_i)
    (in_idle && cmd_end_i && cmd_bad && !abort_i) |=> in_idle ##1 in_idle;
  endproperty
  a_discard_rx: assert property (p_discard_rx)
    else $error("Command received during wait or stop was accepted.");
  property p_abort;
    @(posedge clk_i) disable iff (reset_i)
    abort_i |=> in_idle ##1 !single_wire_debug_pin_oe_o;
  endproperty
  a_abort: assert property (p_abort)
    else $error("Abort did not clear the pending acknowledge.");
  property p_disabled_quiet;
    @(posedge clk_i) disable iff (reset_i)
    (!ack_en_reg && in_wait && done_reg) |=> in_idle && !single_wire_debug_pin_oe_o;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("Acknowledge issued while generation was disabled.");
  property p_exec_req;
    @(posedge clk_i) disable iff (reset_i)
    $rose(in_wait) |-> exec_req_o;
  endproperty
  a_exec_req: assert property (p_exec_req)
    else $error("Accepted command did not request execution.");

endmodule
`default_nettype wire

// ### bench/dla_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Debug host pod and CPU bus stand-in
module dla_host_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // CPU bus side
  input  wire logic [9:0] delay_i,
  input  wire logic       exec_req_i,
  output logic            exec_done_o,
  // Debug pin
  input  wire logic       pin_oe_i,
  input  wire logic       pin_drv_i,
  input  wire logic       host_low_i,
  output logic            pin_o
);
  logic [9:0] wait_reg;

  // The bus may stall for any number of cycles, so the host never times the answer.
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      wait_reg    <= 10'h000;
      exec_done_o <= 1'b0;
    end else begin
      exec_done_o <= 1'b0;
      if (exec_req_i && !exec_done_o) begin
        if (wait_reg == delay_i) begin
          exec_done_o <= 1'b1;
          wait_reg    <= 10'h000;
        end else begin
          wait_reg <= wait_reg + 10'h001;
        end
      end else begin
        wait_reg <= 10'h000;
      end
    end
  end

  // The host only pulls low, and never while the target drives; highs come from the pull-up.
  assign pin_o = pin_oe_i ? pin_drv_i : !host_low_i;
endmodule

`default_nettype wire

// ### bench/debug_link_ack_handshake_tb.sv
`timescale 1ns/10ps
`default_nettype none

module debug_link_ack_handshake_tb;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        cmd_receiving_i = 1'b0;
  logic        cmd_end_i = 1'b0;
  logic        abort_i = 1'b0;
  logic        ack_enable_i = 1'b0;
  logic        ack_disable_i = 1'b0;
  logic        cpu_lowpower_i = 1'b0;
  logic        host_low_i = 1'b0;
  logic [9:0]  dly = 10'h002;
  logic        exec_req_o, exec_done_i, cmd_drop_o, pending_o, ack_busy_o, ack_en_o;
  logic        pin_in, pin_drv, pin_oe, pin_level_o, seen, was_oe, start_ok;
  logic [31:0] seed = 32'h00000056;
  logic [12:0] expq[$];
  int          mismatches = 0;
  int          checks_done = 0;
  int          gap, lowc, spdc;
  localparam logic [12:0] ack_res = {2'h1, 1'h1, 8'h80, 2'h2};

  always #12.5 clk_i = ~clk_i;

  debug_link_ack_handshake debug_link_ack_handshake_inst (
    .clk_i(clk_i), .reset_i(reset_i), .cmd_receiving_i(cmd_receiving_i),
    .cmd_end_i(cmd_end_i), .abort_i(abort_i), .ack_enable_i(ack_enable_i),
    .ack_disable_i(ack_disable_i), .cmd_drop_o(cmd_drop_o), .exec_req_o(exec_req_o),
    .exec_done_i(exec_done_i), .cpu_lowpower_i(cpu_lowpower_i), .pending_o(pending_o),
    .ack_busy_o(ack_busy_o), .ack_en_o(ack_en_o), .single_wire_debug_pin_i(pin_in),
    .single_wire_debug_pin_o(pin_drv), .single_wire_debug_pin_oe_o(pin_oe),
    .pin_level_o(pin_level_o)
  );

  dla_host_model dla_host_model_inst (
    .clk_i(clk_i), .reset_i(reset_i), .delay_i(dly), .exec_req_i(exec_req_o),
    .exec_done_o(exec_done_i), .pin_oe_i(pin_oe), .pin_drv_i(pin_drv),
    .host_low_i(host_low_i), .pin_o(pin_in)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask

  task automatic chk(input bit ok, input string msg);
    checks_done++;
    if (!ok) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic results;
    $display("mismatches %0d, checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic take(input logic [12:0] got);
    logic [12:0] exp;
    exp = (expq.size() == 0) ? 13'h1FFF : expq.pop_front();
    chk(got === exp, "result differs from the oldest expectation");
  endtask

  task automatic send(input logic [9:0] d);
    dly = d;
    cmd_end_i = 1'b1;
    step(1);
    cmd_end_i = 1'b0;
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (!(pending_o === 1'b0 && ack_busy_o === 1'b0 && pin_oe === 1'b0) && n < 3000) begin
      step(1);
      n++;
    end
    chk(n < 3000, "block never returned to idle");
  endtask

  // ==========================================================
  // Result watcher: one note per finished pulse or dropped command
  always @(posedge clk_i) begin
    if (reset_i) begin
      gap = 0;
      seen = 1'b0;
      was_oe = 1'b0;
    end else begin
      gap = cmd_end_i ? 0 : gap + 1;
      seen = cmd_end_i ? 1'b0 : (seen | exec_done_i);
      if (pin_oe === 1'b1 && !was_oe) begin
        start_ok = (gap >= 9'h108) && seen;
        chk(ack_busy_o === 1'b1, "pin driven outside an acknowledge");
        lowc = 0;
        spdc = 0;
      end
      if (pin_oe === 1'b1 && pin_drv === 1'b1) spdc++;
      if (pin_oe === 1'b1 && pin_drv === 1'b0) lowc++;
      if (pin_oe === 1'b0 && was_oe) begin
        take((spdc != 0) ? {2'h1, start_ok, lowc[7:0], spdc[1:0]} : 13'h1800);
      end
      if (cmd_drop_o === 1'b1) take(13'h1000);
      was_oe = (pin_oe === 1'b1);
    end
  end

  initial begin
    #1000000;
    mismatches++;
    $display("wrong value at %0t: watchdog expired", $time);
    results;
  end

  initial begin
    step(20);
    reset_i = 1'b0;
    chk(ack_en_o === 1'b0 && pin_oe === 1'b0 && pin_level_o === 1'b1, "reset state");
    host_low_i = 1'b1;
    step(3);
    chk(pin_level_o === 1'b0, "host low not seen on the pin");
    host_low_i = 1'b0;
    step(3);
    chk(pin_level_o === 1'b1, "released pin not pulled high");
    send(10'h003);
    wait_idle;
    step(300);
    ack_enable_i = 1'b1;
    step(1);
    ack_enable_i = 1'b0;
    chk(ack_en_o === 1'b1, "enable not taken");
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      expq.push_back(ack_res);
      send({5'h00, seed[4:0]} + 10'h002);
      wait_idle;
    end
    expq.push_back(ack_res);
    send(10'h190);
    wait_idle;
    send(10'h0C8);
    step(10);
    cpu_lowpower_i = 1'b1;
    step(2);
    chk(pending_o === 1'b0 && exec_req_o === 1'b0, "pending kept in low power");
    cpu_lowpower_i = 1'b0;
    step(300);
    cpu_lowpower_i = 1'b1;
    expq.push_back(13'h1000);
    send(10'h003);
    cpu_lowpower_i = 1'b0;
    step(300);
    cmd_receiving_i = 1'b1;
    step(3);
    cpu_lowpower_i = 1'b1;
    step(1);
    cpu_lowpower_i = 1'b0;
    step(3);
    expq.push_back(13'h1000);
    send(10'h003);
    cmd_receiving_i = 1'b0;
    step(300);
    expq.push_back(13'h1800);
    send(10'h003);
    step(290);
    abort_i = 1'b1;
    step(1);
    abort_i = 1'b0;
    step(2);
    chk(pin_oe === 1'b0 && pending_o === 1'b0, "abort left the pin driven");
    send(10'h12C);
    step(10);
    abort_i = 1'b1;
    step(1);
    abort_i = 1'b0;
    chk(pending_o === 1'b0, "abort left a command pending");
    step(400);
    ack_disable_i = 1'b1;
    step(1);
    ack_disable_i = 1'b0;
    chk(ack_en_o === 1'b0, "disable not taken");
    step(5);
    chk(expq.size() == 0, "expected results never appeared");
    results;
  end
endmodule

`default_nettype wire
